// ### tcw_consts.vh
`ifndef TCW_CONSTS_VH
`define TCW_CONSTS_VH

// Register word offsets on the Avalon-MM slave.
`define TCW_ADDR_CTRL 3'h0
`define TCW_ADDR_COUNT 3'h1
`define TCW_ADDR_COMPARE 3'h2
`define TCW_ADDR_FLAGS 3'h3
`define TCW_ADDR_PORT 3'h4

// Control register field positions.
`define TCW_CTRL_MODE_LO 0
`define TCW_CTRL_MODE_HI 1
`define TCW_CTRL_ACT_LO 2
`define TCW_CTRL_ACT_HI 3
`define TCW_CTRL_FORCE 4

// Flags register bit positions.
`define TCW_FLAG_CMP 0
`define TCW_FLAG_OVF 1

// Port register bit positions.
`define TCW_PORT_DATA 0
`define TCW_PORT_DIR 1

// Waveform mode encodings.
`define TCW_MODE_NORMAL 2'h0
`define TCW_MODE_PHASE 2'h1
`define TCW_MODE_CLEAR 2'h2
`define TCW_MODE_FAST 2'h3

// Output action encodings.
`define TCW_ACT_NONE 2'h0
`define TCW_ACT_TOGGLE 2'h1
`define TCW_ACT_CLEAR 2'h2
`define TCW_ACT_SET 2'h3

// Counter extremes and reset values.
`define TCW_BOTTOM 8'h00
`define TCW_MAX 8'hFF
`define TCW_RST_BYTE 8'h00
`define TCW_RST_MODE 2'h0
`define TCW_RST_ACT 2'h0
`define TCW_RST_BIT 1'b0
`define TCW_RST_IDLE 1'b1
`define TCW_RST_WORD 32'h00000000

`endif

// ### tcw_timer8_compare.v
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
`include "tcw_consts.vh"

// Summary of operation
// - Force strobe in normal or clear mode acts on latch only, no flag, no clear.
// - Counter write blocks any compare match on the next timer tick, even stopped.
// - Output latch keeps its value when the waveform mode changes.
// - Output action field is not buffered; next match uses the new setting.
// - Reset clears the output latch to zero.
// - Nonzero action field routes latch to pin; direction bit still gates the driver.
// - Action field zero leaves the latch untouched on match in every mode.
// - Normal mode counts up only and wraps from FF to 00.
// - Normal mode sets overflow flag on the tick the counter becomes zero.
// - Clear mode resets the counter to zero on compare match.
// - Clear mode compare writes are immediate; a missed match runs through wrap.
// - Clear mode with action one toggles the latch on every match.
// - Clear mode sets overflow flag on the tick passing from FF to 00.
// - Fast PWM counts zero to FF then clears on the next tick.
// - Fast PWM action two clears on match, sets at bottom; three inverts both.
// - Fast PWM sets overflow flag on each tick that takes the counter from FF to 00.
// - Fast PWM compare zero gives a narrow pulse; compare FF gives a constant level.
// - Fast PWM action one toggles on match with the compare still double buffered.
// - Compare flag is set one timer tick after the match is detected.
// - Compare is double buffered in PWM modes, loaded at bottom; direct otherwise.
// - CPU counter write beats any count or clear in the same cycle.
// - Force strobe bit always reads as zero.
module tcw_timer8_compare (
  input wire core_clk,
  input wire nrst,
  input wire timer_tick,
  input wire [2:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg pin_out,
  output reg pin_oe_n
);

  reg [7:0] counter_value;
  reg [7:0] compare_value;
  reg [7:0] compare_buffer;
  reg [1:0] waveform_mode_field;
  reg [1:0] output_action_field;
  reg compare_output_latch;
  wire compare_match_flag;
  wire overflow_flag;
  reg match_pending;
  reg match_block;
  reg port_data;
  reg output_pin_direction;

  reg next_latch;
  reg [7:0] next_count;
  reg [31:0] next_readdata;

  wire bus_req;
  wire bus_apply;
  wire wr_apply;
  wire wr_ctrl;
  wire wr_count;
  wire wr_compare;
  wire wr_flags;
  wire is_pwm;
  wire is_clear_mode;
  wire at_max;
  wire match;
  wire force_strobe;
  wire cmp_set;
  wire cmp_clear;
  wire ovf_set;
  wire ovf_clear;
  wire event_level;

  // Bus handshake: the first request cycle drops waitrequest, the next edge applies.
  // A write lands only on the edge that also sees waitrequest low, never twice.
  assign bus_req = avs_read | avs_write;
  assign bus_apply = bus_req & ~avs_waitrequest;
  assign wr_apply = avs_write & ~avs_waitrequest;
  assign wr_ctrl = wr_apply & (avs_address == `TCW_ADDR_CTRL);
  assign wr_count = wr_apply & (avs_address == `TCW_ADDR_COUNT);
  assign wr_compare = wr_apply & (avs_address == `TCW_ADDR_COMPARE);
  assign wr_flags = wr_apply & (avs_address == `TCW_ADDR_FLAGS);

  // Mode decode and compare detection.
  // A blocked or untimed cycle never reports a match, so the flag and latch agree.
  assign is_pwm = (waveform_mode_field == `TCW_MODE_FAST) |
                  (waveform_mode_field == `TCW_MODE_PHASE);
  assign is_clear_mode = (waveform_mode_field == `TCW_MODE_CLEAR);
  assign at_max = (counter_value == `TCW_MAX);
  assign match = timer_tick & ~match_block & (counter_value == compare_value);
  assign force_strobe = wr_ctrl & avs_writedata[`TCW_CTRL_FORCE] & ~is_pwm;

  // Non-PWM action level, shared by real matches and the forced strobe.
  tcw_action_level #(
    .WIDTH(2)
  ) u_action (
    .action(output_action_field),
    .level(compare_output_latch),
    .next_level(event_level)
  );

  // Next counter value; a CPU write outranks every count or clear.
  // The increment wraps from FF to 00 on its own; only clear mode forces zero.
  always @* begin
    next_count = counter_value;
    if (wr_count) begin
      next_count = avs_writedata[7:0];
    end else if (timer_tick) begin
      if (is_clear_mode && match) begin
        next_count = `TCW_BOTTOM;
      end else begin
        next_count = counter_value + 8'h01;
      end
    end
  end

  // Next latch value from the action field, the mode and the forced strobe.
  // The action field is read live, so a new setting governs the very next match.
  always @* begin
    next_latch = compare_output_latch;
    if (force_strobe) begin
      next_latch = event_level;
    end else if (waveform_mode_field == `TCW_MODE_FAST) begin
      case (output_action_field)
        `TCW_ACT_TOGGLE: begin
          if (match) begin
            next_latch = ~compare_output_latch;
          end
        end
        `TCW_ACT_CLEAR: begin
          // Bottom wins over a match at FF, so compare FF holds the level.
          if (timer_tick && at_max) begin
            next_latch = 1'b1;
          end else if (match) begin
            next_latch = 1'b0;
          end
        end
        `TCW_ACT_SET: begin
          if (timer_tick && at_max) begin
            next_latch = 1'b0;
          end else if (match) begin
            next_latch = 1'b1;
          end
        end
        default: next_latch = compare_output_latch;
      endcase
    end else if (!is_pwm && match) begin
      next_latch = event_level;
    end
  end

  // Read data mux; the force strobe always reads back as zero.
  // Compare reads return the buffer, so software sees what it wrote in every mode.
  always @* begin
    next_readdata = 32'h00000000;
    case (avs_address)
      `TCW_ADDR_CTRL: begin
        next_readdata[`TCW_CTRL_MODE_HI:`TCW_CTRL_MODE_LO] = waveform_mode_field;
        next_readdata[`TCW_CTRL_ACT_HI:`TCW_CTRL_ACT_LO] = output_action_field;
        next_readdata[`TCW_CTRL_FORCE] = 1'b0;
      end
      `TCW_ADDR_COUNT: next_readdata[7:0] = counter_value;
      `TCW_ADDR_COMPARE: next_readdata[7:0] = compare_buffer;
      `TCW_ADDR_FLAGS: begin
        next_readdata[`TCW_FLAG_CMP] = compare_match_flag;
        next_readdata[`TCW_FLAG_OVF] = overflow_flag;
      end
      `TCW_ADDR_PORT: begin
        next_readdata[`TCW_PORT_DATA] = port_data;
        next_readdata[`TCW_PORT_DIR] = output_pin_direction;
      end
      default: next_readdata = 32'h00000000;
    endcase
  end

  // Avalon-MM slave: waitrequest low for one cycle per request, data ready with it.
  // Read data are captured one edge early and stand while waitrequest is low.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= `TCW_RST_IDLE;
      avs_readdata <= `TCW_RST_WORD;
    end else begin
      if (bus_req && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= next_readdata;
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

  // Control and port registers written by software.
  // The latch is untouched here, so switching modes keeps its level.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      waveform_mode_field <= `TCW_RST_MODE;
      output_action_field <= `TCW_RST_ACT;
      port_data <= `TCW_RST_BIT;
      output_pin_direction <= `TCW_RST_BIT;
    end else begin
      if (wr_ctrl) begin
        waveform_mode_field <= avs_writedata[`TCW_CTRL_MODE_HI:`TCW_CTRL_MODE_LO];
        output_action_field <= avs_writedata[`TCW_CTRL_ACT_HI:`TCW_CTRL_ACT_LO];
      end
      if (wr_apply && avs_address == `TCW_ADDR_PORT) begin
        port_data <= avs_writedata[`TCW_PORT_DATA];
        output_pin_direction <= avs_writedata[`TCW_PORT_DIR];
      end
    end
  end

  // Counter, match blocking and delayed match for the compare flag.
  // The block survives a stopped timer until the next tick has gone by.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      counter_value <= `TCW_RST_BYTE;
      match_block <= `TCW_RST_BIT;
      match_pending <= `TCW_RST_BIT;
    end else begin
      counter_value <= next_count;
      if (wr_count) begin
        match_block <= 1'b1;
      end else if (timer_tick) begin
        match_block <= 1'b0;
      end
      if (timer_tick) begin
        match_pending <= match;
      end
    end
  end

  // Compare value: direct in normal and clear modes, buffered in PWM modes.
  // Buffered loads happen at the FF tick so a period never mixes two duties.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      compare_buffer <= `TCW_RST_BYTE;
      compare_value <= `TCW_RST_BYTE;
    end else begin
      if (wr_compare) begin
        compare_buffer <= avs_writedata[7:0];
      end
      if (wr_compare && !is_pwm) begin
        compare_value <= avs_writedata[7:0];
      end else if (is_pwm && timer_tick && at_max) begin
        compare_value <= compare_buffer;
      end
    end
  end

  // Sticky flags; a hardware set wins over a same-cycle write-one clear.
  // Overflow is held back when software rewrites the counter on the same edge.
  assign cmp_set = timer_tick & match_pending;
  assign cmp_clear = wr_flags & avs_writedata[`TCW_FLAG_CMP];
  assign ovf_set = timer_tick & at_max & ~wr_count;
  assign ovf_clear = wr_flags & avs_writedata[`TCW_FLAG_OVF];

  // Compare match flag, set one tick after the match.
  tcw_sticky_flag #(
    .RST_VALUE(`TCW_RST_BIT)
  ) u_cmp_flag (
    .core_clk(core_clk),
    .nrst(nrst),
    .set_event(cmp_set),
    .clear_req(cmp_clear),
    .flag(compare_match_flag)
  );

  // Overflow flag, set on the tick that leaves FF.
  tcw_sticky_flag #(
    .RST_VALUE(`TCW_RST_BIT)
  ) u_ovf_flag (
    .core_clk(core_clk),
    .nrst(nrst),
    .set_event(ovf_set),
    .clear_req(ovf_clear),
    .flag(overflow_flag)
  );

  // Output latch and pin drive.
  // The driver enable follows the direction bit whatever the action field says.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      compare_output_latch <= `TCW_RST_BIT;
      pin_out <= `TCW_RST_BIT;
      pin_oe_n <= `TCW_RST_IDLE;
    end else begin
      compare_output_latch <= next_latch;
      if (output_action_field != `TCW_ACT_NONE) begin
        pin_out <= next_latch;
      end else begin
        pin_out <= port_data;
      end
      pin_oe_n <= ~output_pin_direction;
    end
  end

endmodule

// Level left in the output latch by a non-PWM compare event.
// Real matches and the forced strobe share it, so both act exactly alike.
module tcw_action_level #(
  parameter WIDTH = 2
) (
  input wire [WIDTH-1:0] action,
  input wire level,
  output reg next_level
);

  // Toggle, clear or set; code zero leaves the level as it is.
  always @* begin
    case (action)
      `TCW_ACT_TOGGLE: next_level = ~level;
      `TCW_ACT_CLEAR: next_level = 1'b0;
      `TCW_ACT_SET: next_level = 1'b1;
      default: next_level = level;
    endcase
  end

endmodule

// One sticky status bit: set by a hardware event, cleared by software writing one.
// When both land on one edge the set wins, so no event is ever lost.
module tcw_sticky_flag #(
  parameter [0:0] RST_VALUE = 1'b0
) (
  input wire core_clk,
  input wire nrst,
  input wire set_event,
  input wire clear_req,
  output reg flag
);

  // Set outranks clear.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flag <= RST_VALUE;
    end else if (set_event) begin
      flag <= 1'b1;
    end else if (clear_req) begin
      flag <= 1'b0;
    end
  end

endmodule

// ### tcw_pin_model.sv
`timescale 1ns/100ps
// Pad as seen from the board: the driven value when enabled, the pull-up otherwise.
module tcw_pin_model (
  input wire pin_out,
  input wire pin_oe_n,
  output wire pad
);
  // A released pin floats high through the external pull-up.
  assign pad = pin_oe_n ? 1'b1 : pin_out;
endmodule

// ### tcw_timer8_compare_assertions.sv
`timescale 1ns/100ps
module tcw_timer8_compare_assertions (
  input wire core_clk,
  input wire nrst,
  input wire timer_tick,
  input wire [2:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire pin_out,
  input wire pin_oe_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Request seen while the slave still waits.
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // Read answered at this edge.
  sequence s_rd;
    avs_read && !avs_waitrequest;
  endsequence
  // Two idle timer cycles with no register write.
  sequence s_quiet;
    (!timer_tick && !avs_write) [*2];
  endsequence
  // Port register write applied at this edge.
  sequence s_port_wr;
    avs_write && !avs_waitrequest && avs_address == 3'h4;
  endsequence
  AST_ONE_WAIT: assert property (s_req |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("wait state count wrong");
  AST_NO_REQ_WAIT: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  AST_FORCE_READ_ZERO: assert property (s_rd and avs_address == 3'h0 |-> !avs_readdata[4])
    else $error("force strobe read as one");
  AST_UNMAPPED_ZERO: assert property (s_rd and avs_address > 3'h4 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_UPPER_ZERO: assert property (s_rd |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  AST_RESET_OUT: assert property ($rose(nrst) |-> !pin_out && pin_oe_n)
    else $error("pin not idle out of reset");
  AST_DIR_GATE: assert property (s_port_wr ##1 1'b1 ##1 1'b1 |-> pin_oe_n == !$past(avs_writedata[1], 2))
    else $error("pin enable does not follow direction bit");
  AST_QUIET_PIN: assert property (s_quiet |=> $stable(pin_out) && $stable(pin_oe_n))
    else $error("pin moved without tick or write");
endmodule

bind tcw_timer8_compare tcw_timer8_compare_assertions u_chk (.core_clk(core_clk), .nrst(nrst),
  .timer_tick(timer_tick), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .pin_out(pin_out), .pin_oe_n(pin_oe_n));

// ### tb_top.sv
`timescale 1ns/100ps
`include "tcw_consts.vh"
module tb_top;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic timer_tick = 1'b0;
  logic [2:0] avs_address = 3'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] q;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, pin_out, pin_oe_n, pad;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  tcw_timer8_compare DUT (.core_clk(core_clk), .nrst(nrst), .timer_tick(timer_tick),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  tcw_pin_model u_pin (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .pad(pad));
  // Clock and hang guard.
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 3000) begin
      mismatches++;
      give_verdict();
    end
  end
  task give_verdict();
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One bus transfer held until waitrequest is sampled low.
  task bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    // Hold everything until waitrequest is sampled low; only the cycle guard ends a hang.
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task wr(input logic [2:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input logic [2:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check("register", q, e);
  endtask
  task ticks(input int n);
    repeat (n) begin
      @(posedge core_clk) timer_tick <= 1'b1;
      @(posedge core_clk) timer_tick <= 1'b0;
    end
  endtask
  task pchk(input logic e);
    repeat (3) @(posedge core_clk);
    check("pad", {31'h0, pad}, {31'h0, e});
  endtask
  // Main sequence.
  initial begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    pchk(1'b1);
    check("pin_out", {31'h0, pin_out}, 32'h0);
    rd(3'h6, 32'h0);
    wr(`TCW_ADDR_CTRL, 32'h0C);
    wr(`TCW_ADDR_CTRL, 32'h1C);
    rd(`TCW_ADDR_CTRL, 32'h0C);
    wr(`TCW_ADDR_PORT, 32'h02);
    pchk(1'b1);
    rd(`TCW_ADDR_FLAGS, 32'h0);
    wr(`TCW_ADDR_CTRL, 32'h0F);
    pchk(1'b1);
    wr(`TCW_ADDR_CTRL, 32'h03);
    pchk(1'b0);
    wr(`TCW_ADDR_CTRL, 32'h08);
    wr(`TCW_ADDR_CTRL, 32'h18);
    wr(`TCW_ADDR_COMPARE, 32'h10);
    wr(`TCW_ADDR_COUNT, 32'h10);
    ticks(2);
    rd(`TCW_ADDR_COUNT, 32'h12);
    rd(`TCW_ADDR_FLAGS, 32'h0);
    wr(`TCW_ADDR_COUNT, 32'h0F);
    ticks(2);
    rd(`TCW_ADDR_FLAGS, 32'h0);
    ticks(1);
    rd(`TCW_ADDR_FLAGS, 32'h1);
    wr(`TCW_ADDR_FLAGS, 32'h3);
    wr(`TCW_ADDR_COUNT, 32'hFE);
    ticks(2);
    rd(`TCW_ADDR_COUNT, 32'h0);
    rd(`TCW_ADDR_FLAGS, 32'h2);
    wr(`TCW_ADDR_CTRL, 32'h06);
    wr(`TCW_ADDR_COMPARE, 32'h03);
    wr(`TCW_ADDR_COUNT, 32'h0);
    wr(`TCW_ADDR_FLAGS, 32'h3);
    ticks(4);
    rd(`TCW_ADDR_COUNT, 32'h0);
    pchk(1'b1);
    ticks(1);
    rd(`TCW_ADDR_FLAGS, 32'h1);
    wr(`TCW_ADDR_FLAGS, 32'h3);
    wr(`TCW_ADDR_COUNT, 32'hFE);
    ticks(2);
    rd(`TCW_ADDR_COUNT, 32'h0);
    rd(`TCW_ADDR_FLAGS, 32'h2);
    wr(`TCW_ADDR_CTRL, 32'h0B);
    wr(`TCW_ADDR_COMPARE, 32'h02);
    wr(`TCW_ADDR_COUNT, 32'hFE);
    wr(`TCW_ADDR_FLAGS, 32'h3);
    ticks(2);
    rd(`TCW_ADDR_COUNT, 32'h0);
    rd(`TCW_ADDR_FLAGS, 32'h2);
    pchk(1'b1);
    wr(`TCW_ADDR_COMPARE, 32'h80);
    ticks(3);
    pchk(1'b0);
    wr(`TCW_ADDR_CTRL, 32'h0F);
    wr(`TCW_ADDR_COUNT, 32'hFE);
    ticks(2);
    wr(`TCW_ADDR_COUNT, 32'h7E);
    ticks(3);
    pchk(1'b1);
    // Action zero in clear mode: matches leave the latch alone.
    wr(`TCW_ADDR_CTRL, 32'h02);
    wr(`TCW_ADDR_COMPARE, 32'h05);
    wr(`TCW_ADDR_COUNT, 32'h04);
    ticks(3);
    rd(`TCW_ADDR_COUNT, 32'h01);
    wr(`TCW_ADDR_CTRL, 32'h0E);
    pchk(1'b1);
    // Fast PWM with compare at FF: the bottom event keeps the level high.
    wr(`TCW_ADDR_CTRL, 32'h0B);
    wr(`TCW_ADDR_COMPARE, 32'hFF);
    wr(`TCW_ADDR_COUNT, 32'hFE);
    ticks(2);
    wr(`TCW_ADDR_COUNT, 32'hFE);
    ticks(2);
    pchk(1'b1);
    // Fast PWM toggle: the new compare only takes hold at the FF tick.
    wr(`TCW_ADDR_CTRL, 32'h07);
    wr(`TCW_ADDR_COMPARE, 32'h01);
    wr(`TCW_ADDR_COUNT, 32'hFE);
    ticks(2);
    pchk(1'b0);
    ticks(2);
    pchk(1'b1);
    // Counter write against a running timer, then a block held while stopped.
    wr(`TCW_ADDR_CTRL, 32'h00);
    wr(`TCW_ADDR_COMPARE, 32'h40);
    timer_tick <= 1'b1;
    wr(`TCW_ADDR_COUNT, 32'h40);
    timer_tick <= 1'b0;
    rd(`TCW_ADDR_COUNT, 32'h40);
    wr(`TCW_ADDR_FLAGS, 32'h3);
    repeat (5) @(posedge core_clk);
    ticks(2);
    rd(`TCW_ADDR_FLAGS, 32'h0);
    give_verdict();
  end
endmodule
